// file: src/idx_pkg.sv
// constants and types for the indirect data addressing block
// assumes a single core clock and an AXI4-Lite master on the register side
package idx_pkg;
	// file address space seen through the bus, one aligned word per file
	localparam int FILE_W = 5;
	localparam int BANK_W = 2;
	localparam int PTR_W_BANKED = 7;
	localparam int PTR_W_FLAT = 5;
	localparam int BYTE_W = 8;
	localparam int ADDR_W = 12;
	localparam int FILE_LSB = 2;
	localparam int RANGE_LSB = 7;
	// file holding no storage: it forwards to the pointed-to location
	localparam logic [FILE_W-1:0] FILE_PORT = 5'h00;
	// file where the pointer register lives
	localparam logic [FILE_W-1:0] FILE_PTR = 5'h04;
	// byte offsets of the two special registers
	localparam logic [ADDR_W-1:0] OFS_PORT = 12'h000;
	localparam logic [ADDR_W-1:0] OFS_PTR = 12'h010;
	// values
	localparam logic [PTR_W_BANKED-1:0] PTR_RST = 7'h00;
	localparam logic [BANK_W-1:0] BANK_UNIMPL = 2'h3;
	localparam logic [BYTE_W-1:0] SELF_READ = 8'h00;
	localparam logic [BYTE_W-1:0] MEM_RST = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		IDX_KIND_SELF,
		IDX_KIND_PTR,
		IDX_KIND_MEM
	} idx_kind_t;
endpackage

// file: src/idx_top.sv
// indirect data addressing: pointer register, forwarding port and banked data memory
// assumes an AXI4-Lite master on aclk; bus held idle while ce is low
//
// The address map and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
module idx_top #(
	parameter bit BANKED = 1'b1
) (
	// clock, reset, enable
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// write address
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [idx_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	// write data
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	// write response
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	// read address
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [idx_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	// read data
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp
);
	localparam int IDXW = BANKED ? idx_pkg::PTR_W_BANKED : idx_pkg::PTR_W_FLAT;
	localparam int DEPTH = 1 << IDXW;

	if (idx_pkg::FILE_W + idx_pkg::FILE_LSB != idx_pkg::RANGE_LSB) begin : g_bad_map
		$error("file field does not fit the address decode");
	end

	// which kind of target a file address reaches after forwarding
	function automatic idx_pkg::idx_kind_t kind_of(input logic [idx_pkg::FILE_W-1:0] f);
		kind_of = idx_pkg::IDX_KIND_MEM;
		if (f == idx_pkg::FILE_PORT) begin
			kind_of = idx_pkg::IDX_KIND_SELF;
		end else if (f == idx_pkg::FILE_PTR) begin
			kind_of = idx_pkg::IDX_KIND_PTR;
		end
	endfunction

	function automatic logic [idx_pkg::FILE_W-1:0] eff_file(
		input logic [idx_pkg::FILE_W-1:0] f,
		input logic [idx_pkg::FILE_W-1:0] p
	);
		eff_file = (f == idx_pkg::FILE_PORT) ? p : f;
	endfunction

	logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
	logic [1:0] bresp_r, rresp_r;
	logic [31:0] rdata_r;
	logic aw_have_r, w_have_r, w_en_r;
	logic [idx_pkg::ADDR_W-1:0] aw_addr_r;
	logic [idx_pkg::BYTE_W-1:0] w_data_r;
	logic [idx_pkg::FILE_W-1:0] ptr_lo_r;
	logic [idx_pkg::BANK_W-1:0] bank_w;
	logic [idx_pkg::PTR_W_BANKED-1:0] ptr_view;
	logic [idx_pkg::BYTE_W-1:0] mem_r [DEPTH];
	logic [DEPTH*idx_pkg::BYTE_W-1:0] mem_flat;

	// handshakes
	wire aw_hs = s_axi_awvalid && awready_r && ce;
	wire w_hs = s_axi_wvalid && wready_r && ce;
	wire b_hs = s_axi_bvalid && s_axi_bready && ce;
	wire ar_hs = s_axi_arvalid && arready_r && ce;
	wire r_hs = s_axi_rvalid && s_axi_rready && ce;
	wire wr_go = aw_have_r && w_have_r && !bvalid_r && ce;

	// read decode
	wire rd_in_range = (s_axi_araddr[idx_pkg::ADDR_W-1:idx_pkg::RANGE_LSB] == '0);
	wire [idx_pkg::FILE_W-1:0] rd_file = s_axi_araddr[idx_pkg::RANGE_LSB-1:idx_pkg::FILE_LSB];
	wire [idx_pkg::FILE_W-1:0] rd_eff = eff_file(rd_file, ptr_lo_r);
	wire idx_pkg::idx_kind_t rd_kind = kind_of(rd_eff);
	wire [IDXW-1:0] rd_idx = IDXW'({bank_w, rd_eff});
	// write decode
	wire wr_in_range = (aw_addr_r[idx_pkg::ADDR_W-1:idx_pkg::RANGE_LSB] == '0);
	wire [idx_pkg::FILE_W-1:0] wr_file = aw_addr_r[idx_pkg::RANGE_LSB-1:idx_pkg::FILE_LSB];
	wire [idx_pkg::FILE_W-1:0] wr_eff = eff_file(wr_file, ptr_lo_r);
	wire idx_pkg::idx_kind_t wr_kind = kind_of(wr_eff);
	wire [IDXW-1:0] wr_idx = IDXW'({bank_w, wr_eff});
	// location the pointer names, bank included
	wire [IDXW-1:0] ptr_idx = IDXW'({bank_w, ptr_lo_r});
	wire wr_do = wr_go && wr_in_range && w_en_r;
	wire mem_we = wr_do && (wr_kind == idx_pkg::IDX_KIND_MEM);
	wire ptr_we = wr_do && (wr_kind == idx_pkg::IDX_KIND_PTR);

	wire [idx_pkg::BYTE_W-1:0] rd_byte =
		(rd_kind == idx_pkg::IDX_KIND_SELF) ? idx_pkg::SELF_READ :
		(rd_kind == idx_pkg::IDX_KIND_PTR) ? {1'b0, ptr_view} : mem_r[rd_idx];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ptr_lo_r <= idx_pkg::PTR_RST[idx_pkg::FILE_W-1:0];
		end else if (ptr_we) begin
			ptr_lo_r <= w_data_r[idx_pkg::FILE_W-1:0];
		end
	end

	generate
		if (BANKED) begin : g_bank
			logic [idx_pkg::BANK_W-1:0] bank_r;
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					bank_r <= idx_pkg::PTR_RST[idx_pkg::PTR_W_BANKED-1:idx_pkg::FILE_W];
				end else if (ptr_we) begin
					bank_r <= w_data_r[idx_pkg::PTR_W_BANKED-1:idx_pkg::FILE_W];
				end
			end
			assign bank_w = bank_r;
			assign ptr_view = {bank_r, ptr_lo_r};
		end else begin : g_flat
			assign bank_w = '0;
			assign ptr_view = {idx_pkg::BANK_UNIMPL, ptr_lo_r};
		end
	endgenerate

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_r[i] <= idx_pkg::MEM_RST;
			end
		end else if (mem_we) begin
			mem_r[wr_idx] <= w_data_r;
		end
	end

	generate
		for (genvar g = 0; g < DEPTH; g++) begin : g_flat_mem
			assign mem_flat[g*idx_pkg::BYTE_W +: idx_pkg::BYTE_W] = mem_r[g];
		end
	endgenerate

	// write channels
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_r <= 1'b1;
			aw_have_r <= 1'b0;
			aw_addr_r <= '0;
		end else if (aw_hs) begin
			awready_r <= 1'b0;
			aw_have_r <= 1'b1;
			aw_addr_r <= s_axi_awaddr;
		end else if (b_hs) begin
			awready_r <= 1'b1;
			aw_have_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wready_r <= 1'b1;
			w_have_r <= 1'b0;
			w_data_r <= '0;
			w_en_r <= 1'b0;
		end else if (w_hs) begin
			wready_r <= 1'b0;
			w_have_r <= 1'b1;
			w_data_r <= s_axi_wdata[idx_pkg::BYTE_W-1:0];
			w_en_r <= s_axi_wstrb[0];
		end else if (b_hs) begin
			wready_r <= 1'b1;
			w_have_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r <= idx_pkg::RESP_OKAY;
		end else if (wr_go) begin
			bvalid_r <= 1'b1;
			bresp_r <= wr_in_range ? idx_pkg::RESP_OKAY : idx_pkg::RESP_SLVERR;
		end else if (b_hs) begin
			bvalid_r <= 1'b0;
		end
	end

	// read channels
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_r <= 1'b1;
			rvalid_r <= 1'b0;
			rdata_r <= '0;
			rresp_r <= idx_pkg::RESP_OKAY;
		end else if (ar_hs) begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b1;
			rdata_r <= rd_in_range ? {24'h000000, rd_byte} : 32'h00000000;
			rresp_r <= rd_in_range ? idx_pkg::RESP_OKAY : idx_pkg::RESP_SLVERR;
		end else if (r_hs) begin
			arready_r <= 1'b1;
			rvalid_r <= 1'b0;
		end
	end

	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	chk_fwd_read_mem: assert property (@(posedge aclk) disable iff (!aresetn)
		(ar_hs && rd_in_range && rd_file == idx_pkg::FILE_PORT && rd_kind == idx_pkg::IDX_KIND_MEM)
		|=> (rdata_r == {24'h000000, $past(mem_flat[ptr_idx*idx_pkg::BYTE_W +: idx_pkg::BYTE_W])}))
		else $error("port read did not return pointed location");

	chk_fwd_write_mem: assert property (@(posedge aclk) disable iff (!aresetn)
		(mem_we && wr_file == idx_pkg::FILE_PORT)
		|=> (mem_flat[$past(ptr_idx)*idx_pkg::BYTE_W +: idx_pkg::BYTE_W] == $past(w_data_r)))
		else $error("port write missed pointed location");

	chk_self_read_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		(ar_hs && rd_in_range && rd_file == idx_pkg::FILE_PORT && ptr_lo_r == '0)
		|=> (rvalid_r && rdata_r == 32'h00000000 && rresp_r == idx_pkg::RESP_OKAY))
		else $error("self read not zero");

	chk_self_write_nop: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_go && wr_file == idx_pkg::FILE_PORT && ptr_lo_r == '0)
		|=> ($stable(mem_flat) && $stable(ptr_view) && bvalid_r))
		else $error("self write changed state");

	// pointer read is seven bits only
	chk_ptr_width: assert property (@(posedge aclk) disable iff (!aresetn)
		(ar_hs && s_axi_araddr == idx_pkg::OFS_PTR)
		|=> (rdata_r[31:idx_pkg::PTR_W_BANKED] == '0 && rdata_r[idx_pkg::FILE_W-1:0] == $past(ptr_lo_r)))
		else $error("pointer read width wrong");

	chk_ptr_low_bits: assert property (@(posedge aclk) disable iff (!aresetn)
		ptr_we |=> (ptr_lo_r == $past(w_data_r[idx_pkg::FILE_W-1:0])))
		else $error("pointer low bits not loaded");

	chk_unimpl_ones: assert property (@(posedge aclk) disable iff (!aresetn)
		(!BANKED && ar_hs && s_axi_araddr == idx_pkg::OFS_PTR)
		|=> (rdata_r[idx_pkg::PTR_W_BANKED-1:idx_pkg::FILE_W] == idx_pkg::BANK_UNIMPL))
		else $error("unimplemented bits not ones");

	// bank bits follow write and steer index
	chk_bank_select: assert property (@(posedge aclk) disable iff (!aresetn)
		(BANKED && ptr_we)
		|=> (ptr_view[idx_pkg::PTR_W_BANKED-1:idx_pkg::FILE_W]
			== $past(w_data_r[idx_pkg::PTR_W_BANKED-1:idx_pkg::FILE_W])) ##1
		((ptr_idx >> idx_pkg::FILE_W)
			== IDXW'($past(w_data_r[idx_pkg::PTR_W_BANKED-1:idx_pkg::FILE_W], 2))))
		else $error("bank bits not applied");

	chk_bresp_timing: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_go |=> (bvalid_r && !awready_r && !wready_r))
		else $error("write response not raised");
endmodule // idx_top

// file: tb/idx_core_model.sv
// bus master standing in for the execution core
// assumes tasks are entered just after a rising aclk edge
`timescale 1ns/1ps
module idx_core_model (
	// clock
	input wire logic aclk,
	// write channels
	output logic awvalid = 1'b0,
	input wire logic awready,
	output logic [11:0] awaddr = 12'h000,
	output logic wvalid = 1'b0,
	input wire logic wready,
	output logic [31:0] wdata = 32'h0,
	output logic [3:0] wstrb = 4'h0,
	input wire logic bvalid,
	output logic bready = 1'b0,
	input wire logic [1:0] bresp,
	// read channels
	output logic arvalid = 1'b0,
	input wire logic arready,
	output logic [11:0] araddr = 12'h000,
	input wire logic rvalid,
	output logic rready = 1'b0,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp
);
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
		input int dly, output logic [1:0] r);
		bit pa = 1;
		bit pw = 1;
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (pa || pw) begin
			@(posedge aclk);
			// released lines stop showing the old value
			if (pa && awready) begin
				pa = 0;
				awvalid <= 1'b0;
				awaddr <= ~a;
			end
			if (pw && wready) begin
				pw = 0;
				wvalid <= 1'b0;
				wdata <= ~d;
			end
		end
		repeat (dly) @(posedge aclk);
		bready <= 1'b1;
		do @(posedge aclk); while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, input int dly, output logic [31:0] d,
		output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		araddr <= ~a;
		repeat (dly) @(posedge aclk);
		rready <= 1'b1;
		do @(posedge aclk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
endmodule // idx_core_model

// file: tb/indirect_data_addressing_test.sv
// self-checking bench: flat (0) and banked (1) variants against an integer model
// assumes idx_core_model drives each variant's bus
`timescale 1ns/1ps
module indirect_data_addressing_test;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic ce = 1'b1;
	int fail_count = 0;
	int checks_done = 0;
	int cyc = 0;
	int ptr [2];
	int mem [2][128];
	always #12.5 aclk = ~aclk;
	for (genvar g = 0; g < 2; g++) begin : gi
		logic awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
		logic [11:0] awa, ara;
		logic [31:0] wd, rd;
		logic [3:0] ws;
		logic [1:0] bre, rre;
		idx_top #(.BANKED(g == 1)) i_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
			.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
			.s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
			.s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bre), .s_axi_arvalid(arv),
			.s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_rvalid(rv),
			.s_axi_rready(rr), .s_axi_rdata(rd), .s_axi_rresp(rre));
		idx_core_model i_core (.aclk(aclk), .awvalid(awv), .awready(awr), .awaddr(awa),
			.wvalid(wv), .wready(wr), .wdata(wd), .wstrb(ws), .bvalid(bv), .bready(br),
			.bresp(bre), .arvalid(arv), .arready(arr), .araddr(ara), .rvalid(rv),
			.rready(rr), .rdata(rd), .rresp(rre));
	end

	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			fail_count++;
			complete_run();
		end
	end

	task automatic cmp(string n, int e, logic [31:0] g);
		checks_done++;
		if (g !== 32'(e)) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", n, 32'(e), g);
		end
	endtask

	// model: 128 = pointer, 256 = port naming itself
	function automatic int tgt(int v, int a);
		int f;
		f = (a >> 2) & 31;
		if (f == 0)
			f = ptr[v] & 31;
		if (f == 0)
			return 256;
		if (f == 4)
			return 128;
		return (v ? (ptr[v] >> 5) & 3 : 0) * 32 + f;
	endfunction

	task automatic op(int v, bit w, int a, int d, int s);
		logic [31:0] q;
		logic [1:0] r;
		int t;
		int dly;
		int e;
		dly = $urandom % 3;
		// frozen cycles with the bus idle; all state must survive them
		if ($urandom % 8 == 0) begin
			ce <= 1'b0;
			repeat (2) @(posedge aclk);
			ce <= 1'b1;
		end
		t = a < 128 ? tgt(v, a) : 512;
		if (w) begin
			if (v) gi[1].i_core.wr(12'(a), 32'(d), 4'(s), dly, r);
			else gi[0].i_core.wr(12'(a), 32'(d), 4'(s), dly, r);
			cmp("bresp", t == 512 ? 2 : 0, 32'(r));
			// self write drops, pointer keeps its width
			if (t == 128 && s[0]) ptr[v] = d & (v ? 127 : 31);
			if (t < 128 && s[0]) mem[v][t] = d & 255;
		end else begin
			if (v) gi[1].i_core.rd(12'(a), dly, q, r);
			else gi[0].i_core.rd(12'(a), dly, q, r);
			cmp("rresp", t == 512 ? 2 : 0, 32'(r));
			e = t == 128 ? (v ? ptr[v] : 96 | ptr[v]) : t < 128 ? mem[v][t] : 0;
			cmp("rdata", e, q);
		end
	endtask

	function automatic int addr();
		int k;
		k = $urandom % 8;
		if (k < 3) return 0;
		if (k == 3) return 16;
		if (k == 4) return 128 + 4 * ($urandom % 992);
		return 4 * ($urandom % 32);
	endfunction

	initial begin
		void'($urandom(3347));
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		for (int v = 0; v < 2; v++) begin
			for (int f = 0; f < 32; f++)
				op(v, 0, f * 4, 0, 0);
			op(v, 1, 0, 165, 1);
			op(v, 1, 16, 127, 1);
			op(v, 0, 16, 0, 0);
			for (int b = 0; b < 4; b++) begin
				op(v, 1, 16, b * 32 + 8, 1);
				op(v, 1, 0, b + 1, 1);
				op(v, 0, 32, 0, 0);
			end
			repeat (300) op(v, $urandom % 2, addr(), $urandom, $urandom % 16);
		end
		complete_run();
	end
endmodule // indirect_data_addressing_test
